// File: logic/status_event_reporting.sv
// Purpose : status registers, summaries, service request and error queue
// Assumes : one decoded command per cycle at most, inputs synchronous to clk_in
// Notes   : every query answers one cycle after it is taken
import status_event_pkg::*;

// Operation
// - an event reaches the status byte only through its set enable bit
// - condition bits follow their conditions live, without any latching
// - event bits set on condition rising edge, hold until read or cleared
// - clear-status command zeroes all event registers
// - questionable bits: 0 voltage, 1 current, 9 overvoltage; others zero
// - reading questionable condition returns it and leaves it unchanged
// - reading questionable event returns it and clears it
// - operation registers exist but no condition ever sets them
// - status byte bits 0 and 1 always read zero
// - status byte bit 2 set while error queue holds an entry
// - status byte bit 3 is masked questionable event summary
// - status byte bit 4 set while output queue holds unread data
// - status byte bit 5 is masked standard event summary
// - status byte bit 6 shows service request, visible in serial poll
// - status byte bit 7 is masked operation event summary
// - summary is OR over all bits of status AND enable
// - standard event bits: opc, zero, four errors, local key, power-on
// - reading standard event register returns it and clears it
// - host writes and reads standard event enable, one-to-one bit mapping
// - host writes and reads service request enable selecting request sources
// - new message clears the output queue; host reads responses first
// - errors queue first-in-first-out; overflow records -350 then blocks
// - error query returns oldest code, or zero when empty
module status_event_reporting #(
    parameter int ERR_DEPTH = 16
) (
    input  wire logic                          clk_in,
    input  wire logic                          sys_rst_in,
    input  wire logic                          cmd_valid_in,
    input  wire status_event_pkg::cmd_req_t    cmd_req_in,
    input  wire logic                          voltage_summary_in,
    input  wire logic                          current_summary_in,
    input  wire logic                          overvoltage_protection_in,
    input  wire status_event_pkg::std_events_t std_events_in,
    input  wire logic                          message_available_in,
    input  wire logic                          message_start_in,
    input  wire logic                          err_push_in,
    input  wire logic [15:0]                   err_code_in,
    output logic                               resp_valid_out,
    output logic [15:0]                        resp_data_out,
    output logic [7:0]                         status_byte_out,
    output logic                               service_request_out,
    output logic                               out_queue_clear_out
);
    import status_event_pkg::*;

    localparam int PTR_W = $clog2(ERR_DEPTH);
    localparam logic [PTR_W:0] DEPTH_CNT = (PTR_W + 1)'(ERR_DEPTH);
    localparam logic [PTR_W:0] LAST_CNT  = (PTR_W + 1)'(ERR_DEPTH - 1);
    localparam logic [PTR_W:0] ONE_CNT   = (PTR_W + 1)'(1);
    localparam logic [PTR_W-1:0] ONE_PTR = PTR_W'(1);

    initial begin
        if (ERR_DEPTH < 2 || (1 << PTR_W) != ERR_DEPTH)
            $error("ERR_DEPTH must be a power of two, at least 2");
    end

    // ==========================================================
    // state
    logic [15:0]      questionable_condition;
    logic [15:0]      questionable_summary_prev;
    logic [15:0]      questionable_event;
    logic [15:0]      questionable_enable;
    logic [15:0]      operation_condition;
    logic [15:0]      operation_event;
    logic [15:0]      operation_enable;
    logic [7:0]       standard_event_status;
    logic [7:0]       standard_event_enable;
    logic [7:0]       service_request_enable;
    logic [15:0]      err_mem [ERR_DEPTH];
    logic [PTR_W-1:0] err_wr;
    logic [PTR_W-1:0] err_rd;
    logic [PTR_W:0]   err_count;
    logic             err_lock;

    logic [15:0]      next_questionable_summary_prev;
    logic [15:0]      next_questionable_event;
    logic [15:0]      next_questionable_enable;
    logic [15:0]      next_operation_event;
    logic [15:0]      next_operation_enable;
    logic [7:0]       next_standard_event_status;
    logic [7:0]       next_standard_event_enable;
    logic [7:0]       next_service_request_enable;
    logic [PTR_W-1:0] next_err_wr;
    logic [PTR_W-1:0] next_err_rd;
    logic [PTR_W:0]   next_err_count;
    logic             next_err_lock;
    logic             err_we;
    logic [15:0]      err_wdata;
    logic             next_resp_valid;
    logic [15:0]      next_resp_data;
    logic [7:0]       next_status_byte;
    logic             next_service_request;

    logic [15:0]      questionable_summary_rise;
    logic [7:0]       std_raw;
    logic [7:0]       summary_byte;
    logic             srq_now;
    logic             cls;
    logic             pop;
    logic             push;
    logic [PTR_W:0]   count_after_pop;

    // ==========================================================
    // condition registers: live, never latched
    always_comb begin
        questionable_condition = ZERO16;
        questionable_condition[QUESTIONABLE_SUMMARY_VOLTAGE_BIT] = voltage_summary_in;
        questionable_condition[QUESTIONABLE_SUMMARY_CURRENT_BIT] = current_summary_in;
        questionable_condition[QUESTIONABLE_SUMMARY_OVP_BIT]     = overvoltage_protection_in;
        operation_condition = ZERO16;
    end

    assign questionable_summary_rise = questionable_condition & ~questionable_summary_prev;
    assign cls = cmd_valid_in && cmd_req_in.cmd == CMD_CLEAR_STATUS;

    always_comb begin
        std_raw = ZERO8;
        std_raw[STD_OPC_BIT] = std_events_in.operation_complete;
        std_raw[STD_QYE_BIT] = std_events_in.query_error;
        std_raw[STD_DDE_BIT] = std_events_in.device_error;
        std_raw[STD_EXE_BIT] = std_events_in.execution_error;
        std_raw[STD_CME_BIT] = std_events_in.command_error;
        std_raw[STD_LKR_BIT] = std_events_in.local_key_request;
    end

    // ==========================================================
    // status byte and service request, from present register state
    always_comb begin
        summary_byte = ZERO8;
        summary_byte[SB_ERROR_BIT] = err_count != '0;
        summary_byte[SB_QUESTIONABLE_SUMMARY_BIT]  = |(questionable_event & questionable_enable);
        summary_byte[SB_MAV_BIT]   = message_available_in;
        summary_byte[SB_ESB_BIT]   = |(standard_event_status & standard_event_enable);
        summary_byte[SB_OPERATION_SUMMARY_BIT]  = |(operation_event & operation_enable);
        srq_now = |(summary_byte & service_request_enable & ~SB_RQS_MASK);
        next_service_request = srq_now;
        next_status_byte = summary_byte;
        next_status_byte[SB_RQS_BIT] = srq_now;
    end

    // ==========================================================
    // registers, error queue and query answers
    always_comb begin
        next_questionable_summary_prev        = questionable_condition;
        next_questionable_event       = questionable_event;
        next_questionable_enable      = questionable_enable;
        next_operation_event  = operation_event;
        next_operation_enable = operation_enable;
        next_standard_event_status  = standard_event_status;
        next_standard_event_enable  = standard_event_enable;
        next_service_request_enable = service_request_enable;
        next_resp_valid = 1'b0;
        next_resp_data  = resp_data_out;
        pop  = 1'b0;
        if (cmd_valid_in) begin
            next_resp_valid = cmd_req_in.cmd != CMD_CLEAR_STATUS
                && cmd_req_in.cmd != CMD_QUESTIONABLE_ENABLE_WR && cmd_req_in.cmd != CMD_OPERATION_ENABLE_WR
                && cmd_req_in.cmd != CMD_STD_ENABLE_WR && cmd_req_in.cmd != CMD_SRQ_ENABLE_WR;
            unique case (cmd_req_in.cmd)
                CMD_CLEAR_STATUS: begin
                    next_questionable_event = ZERO16;
                    next_operation_event = ZERO16;
                    next_standard_event_status = ZERO8;
                end
                CMD_QUESTIONABLE_SUMMARY_COND_RD:   next_resp_data = questionable_condition;
                CMD_QUESTIONABLE_EVENT_RD: begin
                    next_resp_data  = questionable_event;
                    next_questionable_event = ZERO16;
                end
                CMD_QUESTIONABLE_ENABLE_WR: next_questionable_enable = cmd_req_in.data;
                CMD_QUESTIONABLE_ENABLE_RD: next_resp_data = questionable_enable;
                CMD_OPERATION_SUMMARY_COND_RD:   next_resp_data = operation_condition;
                CMD_OPERATION_EVENT_RD: begin
                    next_resp_data = operation_event;
                    next_operation_event = ZERO16;
                end
                CMD_OPERATION_ENABLE_WR: next_operation_enable = cmd_req_in.data;
                CMD_OPERATION_ENABLE_RD: next_resp_data = operation_enable;
                CMD_STATUS_BYTE_RD: next_resp_data = {ZERO8, status_byte_out};
                CMD_STD_EVENT_RD: begin
                    next_resp_data = {ZERO8, standard_event_status};
                    next_standard_event_status = ZERO8;
                end
                CMD_STD_ENABLE_WR:  next_standard_event_enable = cmd_req_in.data[7:0];
                CMD_STD_ENABLE_RD:  next_resp_data = {ZERO8, standard_event_enable};
                CMD_SRQ_ENABLE_WR:  next_service_request_enable = cmd_req_in.data[7:0];
                CMD_SRQ_ENABLE_RD:  next_resp_data = {ZERO8, service_request_enable};
                CMD_ERROR_QUERY: begin
                    pop = err_count != '0;
                    next_resp_data = pop ? err_mem[err_rd] : ERR_NONE;
                end
            endcase
        end
        // a new event in the clearing cycle survives the clear
        next_questionable_event = next_questionable_event | questionable_summary_rise;
        next_standard_event_status = next_standard_event_status | (std_raw & STD_USED_MASK);
        next_operation_event = next_operation_event | operation_condition;

        // error queue: last free slot takes the overflow code, then it blocks
        next_err_wr    = err_wr;
        next_err_rd    = err_rd;
        next_err_count = err_count;
        next_err_lock  = err_lock;
        err_we    = 1'b0;
        err_wdata = err_code_in;
        count_after_pop = pop ? err_count - ONE_CNT : err_count;
        push = err_push_in && !(err_lock && !pop) && count_after_pop != DEPTH_CNT;
        if (cls) begin
            next_err_wr    = '0;
            next_err_rd    = '0;
            next_err_count = '0;
            next_err_lock  = 1'b0;
            push = 1'b0;
        end else begin
            if (pop) begin
                next_err_rd   = err_rd + ONE_PTR;
                next_err_lock = 1'b0;
            end
            next_err_count = count_after_pop;
            if (push) begin
                err_we = 1'b1;
                next_err_wr = err_wr + ONE_PTR;
                next_err_count = count_after_pop + ONE_CNT;
                if (count_after_pop == LAST_CNT) begin
                    err_wdata = ERR_OVERFLOW;
                    next_err_lock = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            questionable_summary_prev        <= ZERO16;
            questionable_event       <= ZERO16;
            questionable_enable      <= ZERO16;
            operation_event  <= ZERO16;
            operation_enable <= ZERO16;
            standard_event_status  <= STD_RESET_VAL;
            standard_event_enable  <= ZERO8;
            service_request_enable <= ZERO8;
            err_wr    <= '0;
            err_rd    <= '0;
            err_count <= '0;
            err_lock  <= 1'b0;
            resp_valid_out      <= 1'b0;
            resp_data_out       <= ZERO16;
            status_byte_out     <= ZERO8;
            service_request_out <= 1'b0;
            out_queue_clear_out <= 1'b0;
        end else begin
            questionable_summary_prev        <= next_questionable_summary_prev;
            questionable_event       <= next_questionable_event;
            questionable_enable      <= next_questionable_enable;
            operation_event  <= next_operation_event;
            operation_enable <= next_operation_enable;
            standard_event_status  <= next_standard_event_status;
            standard_event_enable  <= next_standard_event_enable;
            service_request_enable <= next_service_request_enable;
            err_wr    <= next_err_wr;
            err_rd    <= next_err_rd;
            err_count <= next_err_count;
            err_lock  <= next_err_lock;
            resp_valid_out      <= next_resp_valid;
            resp_data_out       <= next_resp_data;
            status_byte_out     <= next_status_byte;
            service_request_out <= next_service_request;
            out_queue_clear_out <= message_start_in;
        end
    end

    // storage has no reset; entries are only read below the count
    always_ff @(posedge clk_in) begin
        if (err_we)
            err_mem[err_wr] <= err_wdata;
    end

    // ==========================================================
    // assertions
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);

    sequence full_push_s;
        err_push_in && !cls && !pop && !err_lock && err_count == LAST_CNT;
    endsequence
    sequence locked_s;
        err_lock && err_count == DEPTH_CNT;
    endsequence

    questionable_summary_rise_a: assert property ((questionable_summary_rise != ZERO16) |=> ((questionable_event & $past(questionable_summary_rise)) == $past(questionable_summary_rise)))
        else $error("questionable rise not latched");
    questionable_summary_hold_a: assert property ((!cmd_valid_in && questionable_event != ZERO16) |=> ((questionable_event & $past(questionable_event)) == $past(questionable_event)))
        else $error("questionable event dropped without read");
    questionable_summary_read_a: assert property ((cmd_valid_in && cmd_req_in.cmd == CMD_QUESTIONABLE_EVENT_RD)
        |=> resp_valid_out && resp_data_out == $past(questionable_event) && questionable_event == $past(questionable_summary_rise))
        else $error("questionable event read did not return and clear");
    cond_live_a: assert property (##1 questionable_summary_prev == $past(questionable_condition) && (questionable_condition & ~QUESTIONABLE_SUMMARY_USED_MASK) == ZERO16)
        else $error("questionable condition not live");
    cls_a: assert property (cls |=> operation_event == ZERO16 && questionable_event == $past(questionable_summary_rise)
        && standard_event_status == ($past(std_raw) & STD_USED_MASK))
        else $error("clear status left events");
    operation_summary_zero_a: assert property (operation_event == ZERO16 && operation_condition == ZERO16)
        else $error("operation status bit set");
    stb_unused_a: assert property ((status_byte_out & SB_UNUSED_MASK) == ZERO8)
        else $error("unused status byte bits set");
    err_bit_a: assert property (##1 status_byte_out[SB_ERROR_BIT] == $past(err_count != '0))
        else $error("error bit does not track queue");
    esb_a: assert property (##1 status_byte_out[SB_ESB_BIT]
        == $past(|(standard_event_status & standard_event_enable)))
        else $error("event summary bit wrong");
    srq_a: assert property (service_request_out == status_byte_out[SB_RQS_BIT]
        && service_request_out == |(status_byte_out & service_request_enable & ~SB_RQS_MASK)
        || $changed(service_request_enable))
        else $error("service request line disagrees with status byte");
    ovf_a: assert property (full_push_s |=> locked_s ##0 err_mem[err_wr - ONE_PTR] == ERR_OVERFLOW)
        else $error("overflow code not recorded");
    ovf_block_a: assert property ((err_lock && !cls && !pop) |=> $stable(err_count) && $stable(err_wr))
        else $error("queue stored past overflow");
    empty_q_a: assert property ((cmd_valid_in && cmd_req_in.cmd == CMD_ERROR_QUERY && err_count == '0)
        |=> resp_valid_out && resp_data_out == ERR_NONE)
        else $error("empty error query not zero");
    oq_clear_a: assert property (message_start_in |=> out_queue_clear_out)
        else $error("output queue not cleared on new message");

endmodule

// File: logic/status_event_pkg.sv
// Purpose : shared constants and types for the status and event reporting block
// Assumes : one device clock, commands already decoded from the remote messages
// Notes   : bit positions follow the status byte and event register layouts
package status_event_pkg;

    // ==========================================================
    // widths
    localparam int COND_W = 16;
    localparam int BYTE_W = 8;

    // ==========================================================
    // questionable register bit positions
    localparam int QUESTIONABLE_SUMMARY_VOLTAGE_BIT = 0;
    localparam int QUESTIONABLE_SUMMARY_CURRENT_BIT = 1;
    localparam int QUESTIONABLE_SUMMARY_OVP_BIT     = 9;
    localparam logic [15:0] QUESTIONABLE_SUMMARY_USED_MASK = 16'h0203;

    // ==========================================================
    // status byte bit positions
    localparam int SB_ERROR_BIT    = 2;
    localparam int SB_QUESTIONABLE_SUMMARY_BIT     = 3;
    localparam int SB_MAV_BIT      = 4;
    localparam int SB_ESB_BIT      = 5;
    localparam int SB_RQS_BIT      = 6;
    localparam int SB_OPERATION_SUMMARY_BIT     = 7;
    localparam logic [7:0] SB_UNUSED_MASK = 8'h03;
    localparam logic [7:0] SB_RQS_MASK    = 8'h40;

    // ==========================================================
    // standard event register: bit 1 never sets, bit 7 is power-on
    localparam logic [7:0] STD_USED_MASK  = 8'hFD;
    localparam logic [7:0] STD_RESET_VAL  = 8'h80;
    localparam int STD_OPC_BIT = 0;
    localparam int STD_PON_BIT = 7;
    localparam int STD_QYE_BIT = 2;
    localparam int STD_DDE_BIT = 3;
    localparam int STD_EXE_BIT = 4;
    localparam int STD_CME_BIT = 5;
    localparam int STD_LKR_BIT = 6;

    // ==========================================================
    // error codes, two's complement 16 bit
    localparam logic [15:0] ERR_NONE     = 16'h0000;
    localparam logic [15:0] ERR_OVERFLOW = 16'hFEA2; // -350

    localparam logic [15:0] ZERO16 = 16'h0000;
    localparam logic [7:0]  ZERO8  = 8'h00;

    // ==========================================================
    // decoded commands and queries
    typedef enum logic [3:0] {
        CMD_CLEAR_STATUS   = 4'b0000,
        CMD_QUESTIONABLE_SUMMARY_COND_RD   = 4'b0001,
        CMD_QUESTIONABLE_EVENT_RD  = 4'b0010,
        CMD_QUESTIONABLE_ENABLE_WR = 4'b0011,
        CMD_QUESTIONABLE_ENABLE_RD = 4'b0100,
        CMD_OPERATION_SUMMARY_COND_RD   = 4'b0101,
        CMD_OPERATION_EVENT_RD  = 4'b0110,
        CMD_OPERATION_ENABLE_WR = 4'b0111,
        CMD_OPERATION_ENABLE_RD = 4'b1000,
        CMD_STATUS_BYTE_RD = 4'b1001,
        CMD_STD_EVENT_RD   = 4'b1010,
        CMD_STD_ENABLE_WR  = 4'b1011,
        CMD_STD_ENABLE_RD  = 4'b1100,
        CMD_SRQ_ENABLE_WR  = 4'b1101,
        CMD_SRQ_ENABLE_RD  = 4'b1110,
        CMD_ERROR_QUERY    = 4'b1111
    } cmd_t;

    typedef struct packed {
        cmd_t        cmd;
        logic [15:0] data;
    } cmd_req_t;

    typedef struct packed {
        logic operation_complete;
        logic query_error;
        logic device_error;
        logic execution_error;
        logic command_error;
        logic local_key_request;
    } std_events_t;

endpackage

// File: bench/host_model.sv
// Purpose : host side of the command port, one message at a time
// Assumes : every query answers on the taking edge itself, read just after it
// Notes   : the data word is scrambled while no request is held
module host_model (
    input  wire logic                       clk_in,
    input  wire logic [15:0]                resp_data_in,
    output logic                            cmd_valid_out,
    output status_event_pkg::cmd_req_t      cmd_req_out
);
    timeunit 1ns;
    timeprecision 1ps;
    import status_event_pkg::*;
    initial begin
        cmd_valid_out = 1'b0;
        cmd_req_out   = '{CMD_SRQ_ENABLE_RD, 16'h5A5A};
    end
    // ==========================================================
    // one message per call; the answer is taken before the next one
    // enable writes carry the mask in the data word
    task automatic xfer(input cmd_t c, input logic [15:0] d, output logic [15:0] r);
        @(posedge clk_in);
        cmd_valid_out <= 1'b1;
        cmd_req_out   <= '{c, d};
        @(posedge clk_in);
        cmd_valid_out <= 1'b0;
        cmd_req_out   <= '{c, ~d};
        #1 r = resp_data_in;
    endtask
endmodule

// File: bench/status_event_reporting_test.sv
// Purpose : self-checking bench for the status and event reporting block
// Assumes : host model owns the command port, bench owns the live inputs
// Notes   : small error queue so overflow comes after a few pushes
module status_event_reporting_test;
    timeunit 1ns;
    timeprecision 1ps;
    import status_event_pkg::*;
    localparam int DEPTH = 4;
    logic        clk_in, sys_rst_in, cmd_valid, volt, curr, overvoltage_protection, message_available, mstart, epush, resp_valid, srq, oq_clear;
    logic [15:0] ecode, resp_data, r, code_v;
    logic [15:0] codes [DEPTH+1];
    logic [7:0]  status_byte;
    logic [2:0]  q;
    cmd_req_t    cmd_req;
    std_events_t std_ev, e6;
    int          miscompares = 0;
    int          samples_checked = 0;
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin miscompares++; \
    $display("unexpected %s expected %h seen %h", n, e, g); end end
    status_event_reporting #(.ERR_DEPTH(DEPTH)) i_status_event_reporting (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in), .cmd_valid_in(cmd_valid), .cmd_req_in(cmd_req),
        .voltage_summary_in(volt), .current_summary_in(curr), .overvoltage_protection_in(overvoltage_protection),
        .std_events_in(std_ev), .message_available_in(message_available), .message_start_in(mstart),
        .err_push_in(epush), .err_code_in(ecode), .resp_valid_out(resp_valid), .resp_data_out(resp_data),
        .status_byte_out(status_byte), .service_request_out(srq), .out_queue_clear_out(oq_clear));
    host_model i_host_model (.clk_in(clk_in), .resp_data_in(resp_data), .cmd_valid_out(cmd_valid),
        .cmd_req_out(cmd_req));
    // ==========================================================
    // helpers
    function automatic logic [15:0] esr(input std_events_t s);
        return {9'h000, s.local_key_request, s.command_error, s.execution_error, s.device_error,
            s.query_error, 1'b0, s.operation_complete};
    endfunction
    task automatic rd(input cmd_t c, input logic [15:0] e);
        i_host_model.xfer(c, 16'h0000, r);
        `CHK("resp_valid", 1'b1, resp_valid)
        `CHK(c.name(), e, r)
    endtask
    task automatic wr(input cmd_t c, input logic [15:0] d);
        i_host_model.xfer(c, d, r);
    endtask
    // status byte lags the register state by one edge, so give it time
    task automatic sb(input int b, input logic e);
        repeat (3) @(posedge clk_in);
        #1 `CHK("status bit", e, status_byte[b])
        `CHK("service request", status_byte[6], srq)
    endtask
    task automatic pulse_ev(input std_events_t e);
        @(posedge clk_in);
        std_ev <= e;
        @(posedge clk_in);
        std_ev <= '0;
    endtask
    task automatic push(input logic [15:0] c);
        @(posedge clk_in);
        epush <= 1'b1;
        ecode <= c;
        @(posedge clk_in);
        epush <= 1'b0;
        ecode <= ~c;
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // ==========================================================
    // clock, watchdog and tests
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    initial begin
        repeat (5000) @(posedge clk_in);
        miscompares++;
        finish_test();
    end
    initial begin
        void'($urandom(32'h77C0C9AB));
        sys_rst_in = 1'b1;
        {volt, curr, overvoltage_protection, message_available, mstart, epush} = 6'h00;
        std_ev = '0;
        ecode = 16'h0000;
        repeat (3) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        rd(CMD_STD_EVENT_RD, 16'h0080);
        rd(CMD_STD_EVENT_RD, 16'h0000);
        for (int i = 0; i < 6; i++) begin
            e6 = (i == 0) ? 6'h3F : 6'($urandom);
            pulse_ev(e6);
            rd(CMD_STD_EVENT_RD, esr(e6));
        end
        $display("test standard events done");
        for (int i = 0; i < 4; i++) begin
            q = (i == 0) ? 3'b111 : 3'($urandom);
            @(posedge clk_in);
            {overvoltage_protection, curr, volt} <= q;
            rd(CMD_QUESTIONABLE_SUMMARY_COND_RD, {6'h00, q[2], 7'h00, q[1:0]});
            rd(CMD_QUESTIONABLE_SUMMARY_COND_RD, {6'h00, q[2], 7'h00, q[1:0]});
            @(posedge clk_in);
            {overvoltage_protection, curr, volt} <= 3'b000;
            rd(CMD_QUESTIONABLE_EVENT_RD, {6'h00, q[2], 7'h00, q[1:0]});
            rd(CMD_QUESTIONABLE_EVENT_RD, 16'h0000);
        end
        $display("test questionable done");
        @(posedge clk_in);
        {overvoltage_protection, curr, volt} <= 3'b111;
        wr(CMD_QUESTIONABLE_ENABLE_WR, 16'hFDFC);
        rd(CMD_QUESTIONABLE_ENABLE_RD, 16'hFDFC);
        sb(SB_QUESTIONABLE_SUMMARY_BIT, 1'b0);
        wr(CMD_QUESTIONABLE_ENABLE_WR, 16'h0200);
        sb(SB_QUESTIONABLE_SUMMARY_BIT, 1'b1);
        rd(CMD_STATUS_BYTE_RD, 16'h0008);
        wr(CMD_SRQ_ENABLE_WR, 16'h0008);
        rd(CMD_SRQ_ENABLE_RD, 16'h0008);
        sb(SB_RQS_BIT, 1'b1);
        wr(CMD_SRQ_ENABLE_WR, 16'h0040);
        sb(SB_RQS_BIT, 1'b0);
        wr(CMD_STD_ENABLE_WR, 16'h0020);
        rd(CMD_STD_ENABLE_RD, 16'h0020);
        pulse_ev(6'h02);
        sb(SB_ESB_BIT, 1'b1);
        wr(CMD_STD_ENABLE_WR, 16'h00DF);
        sb(SB_ESB_BIT, 1'b0);
        message_available <= 1'b1;
        sb(SB_MAV_BIT, 1'b1);
        message_available <= 1'b0;
        sb(SB_MAV_BIT, 1'b0);
        mstart <= 1'b1;
        @(posedge clk_in);
        mstart <= 1'b0;
        #1 `CHK("queue clear", 1'b1, oq_clear)
        @(posedge clk_in);
        #1 `CHK("queue clear", 1'b0, oq_clear)
        $display("test summaries done");
        wr(CMD_OPERATION_ENABLE_WR, 16'hFFFF);
        rd(CMD_OPERATION_ENABLE_RD, 16'hFFFF);
        rd(CMD_OPERATION_SUMMARY_COND_RD, 16'h0000);
        rd(CMD_OPERATION_EVENT_RD, 16'h0000);
        sb(SB_OPERATION_SUMMARY_BIT, 1'b0);
        `CHK("unused status bits", 2'b00, status_byte[1:0])
        for (int i = 0; i <= DEPTH; i++) begin
            code_v = 16'($urandom) | 16'h8000;
            codes[i] = (i == DEPTH - 1) ? ERR_OVERFLOW : code_v;
            push(code_v);
        end
        sb(SB_ERROR_BIT, 1'b1);
        for (int i = 0; i < DEPTH; i++) rd(CMD_ERROR_QUERY, codes[i]);
        rd(CMD_ERROR_QUERY, ERR_NONE);
        sb(SB_ERROR_BIT, 1'b0);
        push(16'hFF9C);
        wr(CMD_CLEAR_STATUS, 16'h0000);
        sb(SB_ERROR_BIT, 1'b0);
        sb(SB_QUESTIONABLE_SUMMARY_BIT, 1'b0);
        $display("test error queue done");
        finish_test();
    end
endmodule
